// [pg_regs_pkg.sv]
// Purpose: Shared constants and types for the power-good mask and status register slice
// Assumes: 100 MHz core clock, byte-wide registers reached over the two-wire serial port
// Notes: Emergency shutdown counts are derived here and passed to the top as parameter defaults
package pg_regs_pkg;

    // Register offsets
    localparam logic [7:0] MASK_OFS = 8'hac;
    localparam logic [7:0] CTRL_OFS = 8'hae;
    localparam logic [7:0] STAT_LOW_OFS = 8'hb0;
    localparam logic [7:0] STAT_HIGH_OFS = 8'hb1;

    // Values after reset
    localparam logic [7:0] MASK_RST = 8'hff;
    localparam logic [7:0] CTRL_RST = 8'h7d;
    localparam logic [7:0] STAT_RST = 8'h00;

    // Auxiliary regulator control fields
    localparam int DISCHG_LSB = 6;
    localparam int SDWN_BIT = 5;
    localparam int VID_LSB = 1;
    localparam int EN_BIT = 0;
    localparam int HIGH_USED_W = 6;

    // Mask bit positions per status output, index 0..3 = outputs one..four
    localparam int IN3_POS [0:3] = '{7, 3, 1, 5};
    localparam int IN6_POS [0:3] = '{6, 2, 0, 4};

    // Emergency shutdown off-times, selected by factory strap code 0..3
    localparam int CLK_PERIOD_NS = 10;
    localparam int SDWN_T0_MS = 1;
    localparam int SDWN_T1_MS = 5;
    localparam int SDWN_T2_MS = 10;
    localparam int SDWN_T3_MS = 100;
    localparam int SDWN_CYC0 = SDWN_T0_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SDWN_CYC1 = SDWN_T1_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SDWN_CYC2 = SDWN_T2_MS * 1000000 / CLK_PERIOD_NS;
    localparam int SDWN_CYC3 = SDWN_T3_MS * 1000000 / CLK_PERIOD_NS;
    localparam int CNT_W = 24;

    // Serial port: default device address (arbitrary value)
    localparam logic [6:0] DEV_ADDR_DEF = 7'h5e;

    // Pin synchroniser: {rail_high[5:0], rail_low[7:0], in6, in3, scl, sda}
    localparam int PIN_SYNC_W = 18;
    localparam logic [17:0] PIN_SYNC_RST = 18'h00003;

    // Serial port states
    typedef enum logic [5:0] {
        S_IDLE = 6'h01,
        S_ADDR = 6'h02,
        S_ACK = 6'h04,
        S_WRITE = 6'h08,
        S_READ = 6'h10,
        S_RACK = 6'h20
    } ser_state_t;

    // Emergency shutdown states
    typedef enum logic [1:0] {
        E_RUN = 2'h1,
        E_OFF = 2'h2
    } esd_state_t;

endpackage

// [pin_sync3.sv]
// Purpose: Three-stage synchroniser with agreement filter for asynchronous pins
// Assumes: Inputs are quasi-static levels from outside the clock domain
// Notes: Output changes only when stages two and three agree
`timescale 1ns/10ps
module pin_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] s1_reg; // Metastability catcher, read only by s2
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] q_reg; // Filtered level
    logic [W-1:0] q_next;

    // Take a bit only once stages two and three agree, filtering single-cycle glitches
    always_comb begin
        q_next = ((s2_reg ~^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q_reg);
    end

    // Plain shift chain; synchronous reset to the idle pin levels
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            s1_reg <= RST;
            s2_reg <= RST;
            s3_reg <= RST;
            q_reg <= RST;
        end else begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            q_reg <= q_next;
        end
    end

    assign o_q = q_reg;
endmodule

// [power_good_mask_status_regs.sv]
// Purpose: Power-good mask, auxiliary regulator control and rail status registers behind a serial port
// Assumes: Open-drain serial lines with external pull-ups; tree inputs come from same-clock logic
// Notes: Register pointer auto-increments on every data byte, read or written
`timescale 1ns/10ps
module power_good_mask_status_regs
    import pg_regs_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEF,
    parameter int SDWN_CYC_0 = SDWN_CYC0,
    parameter int SDWN_CYC_1 = SDWN_CYC1,
    parameter int SDWN_CYC_2 = SDWN_CYC2,
    parameter int SDWN_CYC_3 = SDWN_CYC3
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_scl,
    input wire logic i_sda_in,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_control_input_three,
    input wire logic i_control_input_six,
    input wire logic [3:0] i_tree_rest_good,
    input wire logic [7:0] i_rail_good_low,
    input wire logic [5:0] i_rail_good_high,
    input wire logic i_emergency_shutdown,
    input wire logic [1:0] i_sdwn_time_sel,
    output logic o_status_out_one,
    output logic o_status_out_two,
    output logic o_status_out_three,
    output logic o_status_out_four,
    output logic o_aux_one_enable,
    output logic [3:0] o_aux_one_voltage_code,
    output logic [1:0] o_aux_one_discharge_sel
);
    logic [PIN_SYNC_W-1:0] pins_q; // Filtered pin levels
    logic sda_q, scl_q, in3_q, in6_q;
    logic [7:0] rail_low_q;
    logic [5:0] rail_high_q;

    // Serial, control-input and rail pins cross through one four-flop filter
    pin_sync3 #(.W(PIN_SYNC_W), .RST(PIN_SYNC_RST)) u_sync (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .i_d({i_rail_good_high, i_rail_good_low, i_control_input_six, i_control_input_three, i_scl, i_sda_in}),
        .o_q(pins_q)
    );
    assign sda_q = pins_q[0];
    assign scl_q = pins_q[1];
    assign in3_q = pins_q[2];
    assign in6_q = pins_q[3];
    assign rail_low_q = pins_q[11:4];
    assign rail_high_q = pins_q[17:12];

    logic [7:0] mask_reg, mask_next; // Control-input mask bits
    logic [7:0] ctrl_reg, ctrl_next; // Auxiliary regulator control

    // Read decode, used only by the serial shifter
    function automatic logic [7:0] reg_read(input logic [7:0] a, input logic [7:0] m, input logic [7:0] c,
                                            input logic [7:0] lo, input logic [5:0] hi);
        logic [7:0] r;
        r = 8'h00;
        case (a)
            MASK_OFS: r = m;
            CTRL_OFS: r = c;
            STAT_LOW_OFS: r = lo;
            STAT_HIGH_OFS: r = {2'b00, hi};
            default: r = 8'h00; // Unmapped reads as zero
        endcase
        return r;
    endfunction

    // Serial port state
    ser_state_t st_reg, st_next;
    logic [7:0] sh_reg, sh_next; // Shift register, in and out
    logic [2:0] bc_reg, bc_next; // Bit counter
    logic [7:0] ptr_reg, ptr_next; // Register pointer
    logic rw_reg, rw_next; // 1 = read transfer
    logic first_reg, first_next; // Next written byte is the pointer
    logic done_reg, done_next; // Eight bits shifted in
    logic nack_reg, nack_next; // Controller declined more data
    logic oe_reg, oe_next; // Pull the data line low
    logic scl_d_reg, sda_d_reg; // Previous filtered levels for edge detect
    logic wr_en; // One-cycle register write strobe
    logic scl_rise, scl_fall, start_cond, stop_cond;
    logic [7:0] rd_byte;

    assign scl_rise = scl_q & ~scl_d_reg;
    assign scl_fall = ~scl_q & scl_d_reg;
    assign start_cond = scl_q & scl_d_reg & sda_d_reg & ~sda_q;
    assign stop_cond = scl_q & scl_d_reg & ~sda_d_reg & sda_q;
    assign rd_byte = reg_read(ptr_reg, mask_reg, ctrl_reg, rail_low_q, rail_high_q);

    // Serial byte engine: sample on rising clock, drive on falling clock
    always_comb begin
        st_next = st_reg;
        sh_next = sh_reg;
        bc_next = bc_reg;
        ptr_next = ptr_reg;
        rw_next = rw_reg;
        first_next = first_reg;
        done_next = done_reg;
        nack_next = nack_reg;
        oe_next = oe_reg;
        wr_en = 1'b0;
        if (start_cond) begin
            // Start or repeated start always restarts the address phase
            st_next = S_ADDR;
            bc_next = 3'd0;
            done_next = 1'b0;
            oe_next = 1'b0;
        end else if (stop_cond) begin
            st_next = S_IDLE;
            oe_next = 1'b0;
        end else if (scl_rise) begin
            case (st_reg)
                S_ADDR, S_WRITE: begin
                    sh_next = {sh_reg[6:0], sda_q};
                    bc_next = bc_reg + 3'd1;
                    if (bc_reg == 3'd7) begin
                        done_next = 1'b1;
                    end
                end
                S_RACK: nack_next = sda_q;
                default: ;
            endcase
        end else if (scl_fall) begin
            case (st_reg)
                S_ADDR: begin
                    if (done_reg) begin
                        done_next = 1'b0;
                        if (sh_reg[7:1] == DEV_ADDR) begin
                            rw_next = sh_reg[0];
                            first_next = 1'b1;
                            oe_next = 1'b1;
                            st_next = S_ACK;
                        end else begin
                            st_next = S_IDLE; // Not ours, stay off the bus
                        end
                    end
                end
                S_WRITE: begin
                    if (done_reg) begin
                        done_next = 1'b0;
                        oe_next = 1'b1;
                        st_next = S_ACK;
                        if (first_reg) begin
                            ptr_next = sh_reg;
                            first_next = 1'b0;
                        end else begin
                            wr_en = 1'b1;
                            ptr_next = ptr_reg + 8'd1;
                        end
                    end
                end
                S_ACK: begin
                    bc_next = 3'd0;
                    if (rw_reg) begin
                        // Data is captured here, so a read sees the status of this moment
                        sh_next = rd_byte;
                        oe_next = ~rd_byte[7];
                        st_next = S_READ;
                    end else begin
                        oe_next = 1'b0;
                        st_next = S_WRITE;
                    end
                end
                S_READ: begin
                    if (bc_reg == 3'd7) begin
                        oe_next = 1'b0;
                        ptr_next = ptr_reg + 8'd1;
                        st_next = S_RACK;
                    end else begin
                        bc_next = bc_reg + 3'd1;
                        sh_next = {sh_reg[6:0], 1'b0};
                        oe_next = ~sh_reg[6];
                    end
                end
                S_RACK: begin
                    if (nack_reg) begin
                        st_next = S_IDLE;
                    end else begin
                        sh_next = rd_byte;
                        oe_next = ~rd_byte[7];
                        bc_next = 3'd0;
                        st_next = S_READ;
                    end
                end
                default: st_next = S_IDLE;
            endcase
        end
    end

    // Serial port registers
    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_reg <= S_IDLE;
            sh_reg <= 8'h00;
            bc_reg <= 3'd0;
            ptr_reg <= 8'h00;
            rw_reg <= 1'b0;
            first_reg <= 1'b0;
            done_reg <= 1'b0;
            nack_reg <= 1'b0;
            oe_reg <= 1'b0;
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            st_reg <= st_next;
            sh_reg <= sh_next;
            bc_reg <= bc_next;
            ptr_reg <= ptr_next;
            rw_reg <= rw_next;
            first_reg <= first_next;
            done_reg <= done_next;
            nack_reg <= nack_next;
            oe_reg <= oe_next;
            scl_d_reg <= scl_q;
            sda_d_reg <= sda_q;
        end
    end

    // Register writes; status and unmapped offsets drop the byte
    always_comb begin
        mask_next = mask_reg;
        ctrl_next = ctrl_reg;
        if (wr_en) begin
            case (ptr_reg)
                MASK_OFS: mask_next = sh_reg;
                CTRL_OFS: ctrl_next = sh_reg;
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            mask_reg <= MASK_RST;
            ctrl_reg <= CTRL_RST;
        end else begin
            mask_reg <= mask_next;
            ctrl_reg <= ctrl_next;
        end
    end

    // Emergency shutdown timer
    esd_state_t esd_reg, esd_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] off_len;

    // Strap code picks the off-time; parameters let simulation shorten it
    always_comb begin
        case (i_sdwn_time_sel)
            2'd0: off_len = CNT_W'(SDWN_CYC_0);
            2'd1: off_len = CNT_W'(SDWN_CYC_1);
            2'd2: off_len = CNT_W'(SDWN_CYC_2);
            default: off_len = CNT_W'(SDWN_CYC_3);
        endcase
    end

    // A repeat event while off restarts the full off-time
    always_comb begin
        esd_next = esd_reg;
        cnt_next = cnt_reg;
        case (esd_reg)
            E_RUN: begin
                if (i_emergency_shutdown && !ctrl_reg[SDWN_BIT]) begin
                    esd_next = E_OFF;
                    cnt_next = off_len;
                end
            end
            E_OFF: begin
                if (i_emergency_shutdown && !ctrl_reg[SDWN_BIT]) begin
                    cnt_next = off_len;
                end else if (cnt_reg <= CNT_W'(1)) begin
                    esd_next = E_RUN;
                end else begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end
            end
            default: esd_next = E_RUN;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            esd_reg <= E_RUN;
            cnt_reg <= '0;
        end else begin
            esd_reg <= esd_next;
            cnt_reg <= cnt_next;
        end
    end

    // Power-good trees: a masked input is forced good
    logic [3:0] tree_good;
    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_tree
            assign tree_good[k] = i_tree_rest_good[k] & (mask_reg[IN3_POS[k]] | in3_q)
                                  & (mask_reg[IN6_POS[k]] | in6_q);
        end
    endgenerate

    // Output flops
    logic [3:0] out_reg, out_next;
    logic ldo_on_reg, ldo_on_next;
    logic [3:0] vid_reg, vid_next;
    logic [1:0] dis_reg, dis_next;

    always_comb begin
        out_next = tree_good;
        // Config 1 ignores the shutdown timer entirely
        ldo_on_next = ctrl_reg[EN_BIT] & (ctrl_reg[SDWN_BIT] | (esd_reg == E_RUN));
        vid_next = ctrl_reg[VID_LSB +: 4];
        dis_next = ctrl_reg[DISCHG_LSB +: 2];
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            out_reg <= 4'h0;
            ldo_on_reg <= 1'b0;
            vid_reg <= 4'h0;
            dis_reg <= 2'h0;
        end else begin
            out_reg <= out_next;
            ldo_on_reg <= ldo_on_next;
            vid_reg <= vid_next;
            dis_reg <= dis_next;
        end
    end

    assign o_status_out_one = out_reg[0];
    assign o_status_out_two = out_reg[1];
    assign o_status_out_three = out_reg[2];
    assign o_status_out_four = out_reg[3];
    assign o_aux_one_enable = ldo_on_reg;
    assign o_aux_one_voltage_code = vid_reg;
    assign o_aux_one_discharge_sel = dis_reg;
    assign o_sda_oe = oe_reg;
    assign o_sda_out = 1'b0; // Open drain: only ever pulls low

    // Checks
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);

    out_one_mask_a: assert property ((mask_reg[7:6] == 2'b11 && i_tree_rest_good[0]) |=> o_status_out_one)
        else $error("output one not good with both inputs masked");
    out_four_in3_a: assert property ((!mask_reg[5] && !in3_q) |=> !o_status_out_four)
        else $error("output four ignored unmasked input three");
    out_two_in6_a: assert property ((!mask_reg[2] && !in6_q) |=> !o_status_out_two)
        else $error("output two ignored unmasked input six");
    out_three_mask_a: assert property ((mask_reg[1:0] == 2'b11 && i_tree_rest_good[2]) |=> o_status_out_three)
        else $error("output three not good with both inputs masked");
    mask_reset_a: assert property (disable iff (1'b0) !i_rstn |=> mask_reg == MASK_RST)
        else $error("mask register reset value wrong");
    dischg_write_a: assert property ((wr_en && ptr_reg == CTRL_OFS)
        |-> ##2 o_aux_one_discharge_sel == $past(sh_reg[7:6], 2))
        else $error("discharge select did not follow write");
    esd_off_a: assert property ((esd_reg == E_RUN && i_emergency_shutdown && !ctrl_reg[SDWN_BIT])
        |-> ##2 !o_aux_one_enable)
        else $error("regulator stayed on in emergency shutdown");
    en_only_a: assert property ((ctrl_reg[SDWN_BIT] && $stable(ctrl_reg))
        |=> o_aux_one_enable == $past(ctrl_reg[EN_BIT]))
        else $error("regulator enable did not follow enable bit");
    vid_write_a: assert property ((wr_en && ptr_reg == CTRL_OFS)
        |-> ##2 o_aux_one_voltage_code == $past(sh_reg[4:1], 2))
        else $error("voltage code did not follow write");
    ctrl_reset_a: assert property (disable iff (1'b0) !i_rstn |=> ctrl_reg == CTRL_RST)
        else $error("control register reset value wrong");
    stat_reset_a: assert property (disable iff (1'b0) !i_rstn
        |=> (rail_low_q == STAT_RST && rail_high_q == 6'h00))
        else $error("status not zero after reset");
    // Watch the byte actually loaded for shifting out, not the decode alone
    high_rsvd_a: assert property ((st_reg == S_ACK && rw_reg && scl_fall && ptr_reg == STAT_HIGH_OFS)
        |=> sh_reg[7:6] == 2'b00)
        else $error("reserved status bits not zero");
    stat_wr_a: assert property ((wr_en && ptr_reg[7:4] == 4'hb) |=> ($stable(mask_reg) && $stable(ctrl_reg)))
        else $error("status write changed a register");

    mask_wr_c: cover property (wr_en && ptr_reg == MASK_OFS);
    esd_run_c: cover property (esd_reg == E_OFF ##1 esd_reg == E_RUN);
    read_c: cover property (st_reg == S_RACK && scl_fall && !nack_reg);
    out_rise_c: cover property ($rose(o_status_out_one));
endmodule

// [ser_host.sv]
// Purpose: Two-wire serial host standing in for the system controller
// Assumes: Open-drain data line; the bench adds the pull-up
// Notes: Data changes well after clock falls, so the pin filters never see a false start or stop
`timescale 1ns/10ps
module ser_host #(
    parameter logic [6:0] DEV = 7'h00,
    parameter int HALF = 10
) (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_pull
);
    logic ack_ok; // Every byte of the last transfer, bar the refused read byte, was acknowledged
    initial begin
        o_scl = 1'b1;
        o_sda_pull = 1'b0;
        ack_ok = 1'b0;
    end
    // Waits on falling edges, where all host signals change
    task automatic hw(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    // Start or repeated start: data falls while clock is high
    task automatic start();
        hw(3);
        o_sda_pull = 1'b0;
        hw(HALF);
        o_scl = 1'b1;
        hw(HALF);
        o_sda_pull = 1'b1;
        hw(HALF);
        o_scl = 1'b0;
    endtask
    // Stop: data rises while clock is high, then the bus idles high
    task automatic stop();
        hw(3);
        o_sda_pull = 1'b1;
        hw(HALF);
        o_scl = 1'b1;
        hw(HALF);
        o_sda_pull = 1'b0;
        hw(HALF);
    endtask
    // One bit; the line is sampled just before the clock falls
    task automatic one_bit(input logic b, output logic s);
        hw(3);
        o_sda_pull = ~b;
        hw(HALF);
        o_scl = 1'b1;
        hw(HALF);
        s = i_sda;
        o_scl = 1'b0;
    endtask
    // Byte out MSB first plus ninth bit; sending ff reads a byte
    task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) begin
            one_bit(d[i], q[i]);
        end
        one_bit(m, a);
    endtask
    // Register write: address, pointer, data
    task automatic wr(input logic [7:0] r, input logic [7:0] d);
        logic [7:0] q;
        logic a0, a1, a2;
        start();
        xfer({DEV, 1'b0}, 1'b1, q, a0);
        xfer(r, 1'b1, q, a1);
        xfer(d, 1'b1, q, a2);
        stop();
        ack_ok = ~(a0 | a1 | a2);
    endtask
    // Register read: set pointer, repeated start, one byte ended by a refusal
    task automatic rd(input logic [7:0] r, output logic [7:0] d);
        logic [7:0] q;
        logic a0, a1, a2, a3;
        start();
        xfer({DEV, 1'b0}, 1'b1, q, a0);
        xfer(r, 1'b1, q, a1);
        start();
        xfer({DEV, 1'b1}, 1'b1, q, a2);
        xfer(8'hff, 1'b1, d, a3);
        stop();
        ack_ok = ~(a0 | a1 | a2);
    endtask
    // Address byte alone, to see whether anyone answers
    task automatic probe(input logic [6:0] ad);
        logic [7:0] q;
        logic a;
        start();
        xfer({ad, 1'b0}, 1'b1, q, a);
        stop();
        ack_ok = ~a;
    endtask
endmodule

// [power_good_mask_status_regs_tb.sv]
// Purpose: Self-checking bench for the mask, regulator control and status registers
// Assumes: Shortened shutdown counts; serial host model drives the bus
// Notes: Inputs change on falling clock edges only
`timescale 1ns/10ps
`define CHK(nm, e, g) begin \
    tests_run++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("BAD %s exp %h got %h", nm, e, g); \
    end \
end
module power_good_mask_status_regs_tb;
    import pg_regs_pkg::*;
    localparam int CYC [0:3] = '{20, 40, 60, 80}; // Short off-times keep the run brief
    logic clk, rstn, scl, pull, in3, in6, esd, sda_oe, o1, o2, o3, o4, en;
    logic [3:0] rest, code;
    logic [7:0] rlo, d, m;
    logic [5:0] rhi;
    logic [1:0] tsel, dis;
    int err_count, tests_run, n;
    int p3 [0:3] = '{7, 3, 1, 5}; // Mask bit of input three per output one..four
    int p6 [0:3] = '{6, 2, 0, 4}; // Mask bit of input six per output one..four
    logic sdo; // Level the device puts on the data line while enabled
    wire sda = ~pull & (sda_oe ? sdo : 1'b1); // Pull-up; either party may pull low
    power_good_mask_status_regs #(.SDWN_CYC_0(CYC[0]), .SDWN_CYC_1(CYC[1]), .SDWN_CYC_2(CYC[2]),
        .SDWN_CYC_3(CYC[3])) u_dut (.i_clk(clk), .i_rstn(rstn), .i_scl(scl), .i_sda_in(sda),
        .o_sda_out(sdo), .o_sda_oe(sda_oe), .i_control_input_three(in3), .i_control_input_six(in6),
        .i_tree_rest_good(rest), .i_rail_good_low(rlo), .i_rail_good_high(rhi), .i_emergency_shutdown(esd),
        .i_sdwn_time_sel(tsel), .o_status_out_one(o1), .o_status_out_two(o2), .o_status_out_three(o3),
        .o_status_out_four(o4), .o_aux_one_enable(en), .o_aux_one_voltage_code(code),
        .o_aux_one_discharge_sel(dis));
    ser_host #(.DEV(DEV_ADDR_DEF)) u_host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda_pull(pull));
    // Expected outputs {four,three,two,one}; a masked input counts as good
    function automatic logic [3:0] tree(input logic [7:0] mk, input logic a, input logic b, input logic [3:0] r);
        for (int k = 0; k < 4; k++) begin
            tree[k] = r[k] & (mk[p3[k]] | a) & (mk[p6[k]] | b);
        end
    endfunction
    // Pulses the shutdown event and counts the cycles the regulator is off
    task automatic esd_run(output int c);
        int w;
        c = 0;
        w = 0;
        esd = 1'b1;
        @(negedge clk);
        esd = 1'b0;
        while (en === 1'b1 && w < 10) begin
            @(negedge clk);
            w++;
        end
        while (en === 1'b0 && c < 300) begin
            @(negedge clk);
            c++;
        end
    endtask
    // Verdict and end of run
    task automatic end_sim();
        if (err_count == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Watchdog sized well above the expected run of some 32000 cycles
    initial begin
        repeat (90000) @(posedge clk);
        err_count++;
        end_sim();
    end
    initial begin
        {rstn, esd, rlo, rhi, tsel} = '0;
        {in3, in6, rest} = 6'h3f;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("enable", 1'b1, en)
        `CHK("vcode", 4'he, code)
        `CHK("dischg", 2'h1, dis)
        u_host.rd(8'hac, d);
        `CHK("mask rst", 8'hff, d)
        u_host.rd(8'hae, d);
        `CHK("ctrl rst", 8'h7d, d)
        `CHK("ack", 1'b1, u_host.ack_ok)
        u_host.rd(8'hb0, d);
        `CHK("stat lo rst", 8'h00, d)
        u_host.rd(8'hb1, d);
        `CHK("stat hi rst", 8'h00, d)
        // Live rails; writes to status and to a hole must change nothing
        rlo = 8'ha5;
        rhi = 6'h3f;
        u_host.wr(8'hb0, 8'h5a);
        u_host.wr(8'hb1, 8'h00);
        u_host.wr(8'had, 8'h55);
        u_host.rd(8'hb0, d);
        `CHK("stat lo", 8'ha5, d)
        u_host.rd(8'hb1, d);
        `CHK("stat hi", 8'h3f, d)
        u_host.rd(8'had, d);
        `CHK("hole", 8'h00, d)
        u_host.probe(DEV_ADDR_DEF ^ 7'h01);
        `CHK("foreign ack", 1'b0, u_host.ack_ok)
        // Each mask bit alone, its input low then high
        for (int k = 0; k < 4; k++) begin
            for (int s = 0; s < 2; s++) begin
                m = 8'hff & ~(8'h01 << (s ? p6[k] : p3[k]));
                u_host.wr(8'hac, m);
                u_host.rd(8'hac, d);
                `CHK("mask", m, d)
                for (int v = 0; v < 2; v++) begin
                    in3 = s ? 1'b1 : v[0];
                    in6 = s ? v[0] : 1'b1;
                    repeat (10) @(negedge clk);
                    `CHK("outs", tree(m, in3, in6, rest), {o4, o3, o2, o1})
                end
            end
        end
        rest = 4'h5;
        repeat (4) @(negedge clk);
        `CHK("outs rest", 4'h5, {o4, o3, o2, o1})
        // Every discharge code with shutdown config 1, code 2, enabled
        for (int i = 0; i < 4; i++) begin
            m = {i[1:0], 6'h25};
            u_host.wr(8'hae, m);
            u_host.rd(8'hae, d);
            `CHK("ctrl", m, d)
            `CHK("dischg", i[1:0], dis)
            `CHK("vcode", 4'h2, code)
        end
        u_host.wr(8'hae, 8'h3c);
        `CHK("disabled", 1'b0, en)
        u_host.wr(8'hae, 8'h3d);
        esd_run(n);
        `CHK("no esd off", 0, n)
        // Config 0: each strap selects its own off-time
        u_host.wr(8'hae, 8'h1d);
        for (int t = 0; t < 4; t++) begin
            tsel = t[1:0];
            @(negedge clk);
            esd_run(n);
            `CHK("off time", CYC[t], n)
        end
        `CHK("back on", 1'b1, en)
        // A reset in mid-run must bring the defaults back
        rstn = 1'b0;
        repeat (10) @(negedge clk);
        rstn = 1'b1;
        repeat (8) @(negedge clk);
        `CHK("enable again", 1'b1, en)
        `CHK("vcode again", 4'he, code)
        u_host.rd(8'hac, d);
        `CHK("mask again", 8'hff, d)
        end_sim();
    end
endmodule
